// >>> hw/sram_wmask_top.sv
// write port with per-beat lane masking and a two-beat read port
`timescale 1ns/1ps
`default_nettype none
module sram_wmask_top #(
    parameter sram_wmask_pkg::width_cfg_type CFG = sram_wmask_pkg::CFG_X36,
    parameter int ADDR_W = 10
) (
    input  wire logic                             i_clk_sys,
    input  wire logic                             i_rst,
    input  wire logic                             i_k,
    input  wire logic                             i_k_n,
    input  wire logic                             i_c,
    input  wire logic                             i_c_n,
    input  wire logic                             i_write_port_select_n,
    input  wire logic                             i_read_port_select_n,
    input  wire logic [ADDR_W-1:0]                i_addr,
    input  wire logic [sram_wmask_pkg::MAX_W-1:0] i_data,
    input  wire logic                             i_lane0_write_select_n,
    input  wire logic                             i_lane1_write_select_n,
    input  wire logic                             i_lane2_write_select_n,
    input  wire logic                             i_lane3_write_select_n,
    input  wire logic                             i_low_half_write_select_n,
    input  wire logic                             i_high_half_write_select_n,
    output logic [sram_wmask_pkg::MAX_W-1:0]      o_rdata,
    output logic                                  o_rdata_oe,
    output logic                                  o_single_clock
);

    // ============================================================
    // edge detection
    logic k_q, kn_q, c_q, cn_q;
    logic k_rise, kn_rise, hi_launch, lo_launch;
    logic strap_done_q;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            k_q  <= 1'b0;
            kn_q <= 1'b0;
            c_q  <= 1'b0;
            cn_q <= 1'b0;
        end else begin
            k_q  <= i_k;
            kn_q <= i_k_n;
            c_q  <= i_c;
            cn_q <= i_c_n;
        end
    end

    assign k_rise    = i_k & ~k_q;
    assign kn_rise   = i_k_n & ~kn_q;
    assign hi_launch = o_single_clock ? k_rise : (i_c & ~c_q);
    assign lo_launch = o_single_clock ? kn_rise : (i_c_n & ~cn_q);

    // strap caught once after reset release: both output clocks high
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            strap_done_q   <= 1'b0;
            o_single_clock <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q   <= 1'b1;
            o_single_clock <= i_c & i_c_n;
        end
    end

    // ============================================================
    // lane select gathering
    logic [sram_wmask_pkg::LANES-1:0] sel_now;

    always_comb begin
        case (CFG)
            sram_wmask_pkg::CFG_X8:  sel_now = {2'h3, i_high_half_write_select_n, i_low_half_write_select_n};
            sram_wmask_pkg::CFG_X9:  sel_now = {3'h7, i_lane0_write_select_n};
            sram_wmask_pkg::CFG_X18: sel_now = {2'h3, i_lane1_write_select_n, i_lane0_write_select_n};
            default: sel_now = {i_lane3_write_select_n, i_lane2_write_select_n,
                                i_lane1_write_select_n, i_lane0_write_select_n};
        endcase
    end

    // ============================================================
    // write burst capture
    typedef enum logic {
        WR_IDLE  = 1'b0,
        WR_BEAT2 = 1'b1
    } wr_state_type;

    wr_state_type             wr_state_q;
    sram_wmask_pkg::beat_type beat0_q;
    logic [ADDR_W-1:0]        wr_addr_q;
    logic                     wr_start;
    logic                     wr_commit;

    assign wr_start  = (wr_state_q == WR_IDLE) && k_rise && !i_write_port_select_n;
    assign wr_commit = (wr_state_q == WR_BEAT2) && kn_rise;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wr_state_q <= WR_IDLE;
        end else begin
            case (wr_state_q)
                WR_IDLE:  if (wr_start) wr_state_q <= WR_BEAT2;
                WR_BEAT2: if (kn_rise) wr_state_q <= WR_IDLE;
                default:  wr_state_q <= WR_IDLE;
            endcase
        end
    end

    // first beat and its selects taken with the positive clock rise
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            beat0_q   <= '0;
            wr_addr_q <= '0;
        end else if (wr_start) begin
            beat0_q.data  <= i_data;
            beat0_q.sel_n <= sel_now;
            wr_addr_q     <= i_addr;
        end
    end

    // ============================================================
    // array commit, both beats as one line write
    logic                              mem_we_q;
    logic [ADDR_W-1:0]                 mem_waddr_q;
    logic [sram_wmask_pkg::LINE_W-1:0] mem_wdata_q;
    logic [sram_wmask_pkg::LINE_W-1:0] mem_ben_q;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            mem_we_q    <= 1'b0;
            mem_waddr_q <= '0;
            mem_wdata_q <= '0;
            mem_ben_q   <= '0;
        end else begin
            mem_we_q <= wr_commit;
            if (wr_commit) begin
                mem_waddr_q <= wr_addr_q;
                mem_wdata_q <= {i_data, beat0_q.data};
                mem_ben_q   <= {sram_wmask_pkg::lane_mask(CFG, sel_now),
                                sram_wmask_pkg::lane_mask(CFG, beat0_q.sel_n)};
            end
        end
    end

    // ============================================================
    // read burst
    typedef enum logic [2:0] {
        RD_IDLE  = 3'b000,
        RD_WAIT  = 3'b001,
        RD_FETCH = 3'b010,
        RD_BEAT0 = 3'b011,
        RD_BEAT1 = 3'b100
    } rd_state_type;

    rd_state_type                      rd_state_q;
    logic [ADDR_W-1:0]                 rd_addr_q;
    logic [sram_wmask_pkg::LINE_W-1:0] rd_line;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rd_state_q <= RD_IDLE;
            rd_addr_q  <= '0;
            o_rdata    <= sram_wmask_pkg::DATA_RESET;
            o_rdata_oe <= 1'b0;
        end else begin
            case (rd_state_q)
                RD_IDLE: if (k_rise && !i_read_port_select_n) begin
                    rd_addr_q  <= i_addr;
                    rd_state_q <= RD_WAIT;
                end
                RD_WAIT: if (k_rise) rd_state_q <= RD_FETCH;
                RD_FETCH: if (lo_launch) begin
                    o_rdata    <= rd_line[sram_wmask_pkg::MAX_W-1:0];
                    o_rdata_oe <= 1'b1;
                    rd_state_q <= RD_BEAT0;
                end
                RD_BEAT0: if (hi_launch) begin
                    o_rdata    <= rd_line[sram_wmask_pkg::LINE_W-1:sram_wmask_pkg::MAX_W];
                    rd_state_q <= RD_BEAT1;
                end
                RD_BEAT1: if (lo_launch) begin
                    o_rdata_oe <= 1'b0;
                    rd_state_q <= RD_IDLE;
                end
                default: rd_state_q <= RD_IDLE;
            endcase
        end
    end

    sram_line_mem #(
        .ADDR_W (ADDR_W),
        .DATA_W (sram_wmask_pkg::LINE_W)
    ) u_mem (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_we      (mem_we_q),
        .i_waddr   (mem_waddr_q),
        .i_wdata   (mem_wdata_q),
        .i_ben     (mem_ben_q),
        .i_raddr   (rd_addr_q),
        .o_rdata   (rd_line)
    );

    // ============================================================
    // assertions
    sequence s_write_open;
        wr_start;
    endsequence

    sequence s_second_beat;
        (wr_state_q == WR_BEAT2) && kn_rise;
    endsequence

    a_commit_follows: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_second_beat |=> mem_we_q)
        else $error("second beat not committed");

    a_commit_cause: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        mem_we_q |-> $past(wr_state_q == WR_BEAT2) && $past(kn_rise))
        else $error("commit without a second beat");

    a_addr_latch: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_second_beat |=> mem_we_q && mem_waddr_q == $past(wr_addr_q))
        else $error("commit address differs from latched one");

    a_beat0_sample: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_write_open |=> beat0_q.sel_n == $past(sel_now) && beat0_q.data == $past(i_data))
        else $error("first beat selects not sampled");

    a_beat1_data: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_second_beat |=> mem_wdata_q[71:36] == $past(i_data)
                          && mem_ben_q[71:36] == sram_wmask_pkg::lane_mask(CFG, $past(sel_now)))
        else $error("second beat data or selects wrong");

    a_x8_nibbles: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (CFG == sram_wmask_pkg::CFG_X8) && mem_we_q |->
        mem_ben_q[35:0] == {28'h0000000, {4{~$past(beat0_q.sel_n[1])}}, {4{~$past(beat0_q.sel_n[0])}}})
        else $error("nibble enables wrong");

    a_x18_lanes: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (CFG == sram_wmask_pkg::CFG_X18) && mem_we_q |->
        mem_ben_q[35:0] == {18'h00000, {9{~$past(beat0_q.sel_n[1])}}, {9{~$past(beat0_q.sel_n[0])}}})
        else $error("18-bit lane enables wrong");

    a_x9_lane: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (CFG == sram_wmask_pkg::CFG_X9) && mem_we_q |->
        mem_ben_q[35:0] == {27'h0000000, {9{~$past(beat0_q.sel_n[0])}}})
        else $error("9-bit lane enable wrong");

    a_x36_lanes: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (CFG == sram_wmask_pkg::CFG_X36) && mem_we_q |->
        mem_ben_q[35:0] == {{9{~$past(beat0_q.sel_n[3])}}, {9{~$past(beat0_q.sel_n[2])}},
                            {9{~$past(beat0_q.sel_n[1])}}, {9{~$past(beat0_q.sel_n[0])}}})
        else $error("36-bit lane enables wrong");

    a_all_high_none: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (s_second_beat and (&sel_now)) |=> mem_we_q && mem_ben_q[71:36] == 36'h000000000)
        else $error("masked beat still written");

    a_idle_undriven: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (rd_state_q == RD_IDLE) && $past(rd_state_q == RD_IDLE) |-> !o_rdata_oe)
        else $error("read outputs driven while deselected");

    a_read_launch: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (rd_state_q == RD_FETCH) && lo_launch |=> o_rdata_oe && (rd_state_q == RD_BEAT0))
        else $error("first read beat not launched");

endmodule : sram_wmask_top
`default_nettype wire

// >>> hw/sram_wmask_pkg.sv
// constants, types and lane mask functions for the sram write masking block
// ============================================================
// Overview of operation
// - In the 8-bit setup, data bits 3:0 are written only when the low half select is low and bits 7:4 only when the high half select is low.
// - In the 18-bit setup, lane bits 8:0 follow the first lane select and bits 17:9 the second, a high select keeping the lane.
// - In the 9-bit setup, one lane select writes the whole 9-bit beat when low and nothing when high.
// - In the 36-bit setup, four lane selects gate bits 8:0, 17:9, 26:18 and 35:27, each high select keeping its lane.
// - A beat whose sampled selects are all high writes nothing, while the rest of the burst goes on.
// - Selects are sampled per beat: with the first beat on the positive clock rise, the second on the negative clock rise.
// - Write data is taken on rising edges of both input clocks and read data is launched on the output clock pair, or the input clocks in single clock mode.
// - The two beats of a burst go to the low and high halves of the one line at the latched location.
// - After reset the device is deselected with its read outputs not driven until a transaction starts.
package sram_wmask_pkg;

    localparam int MAX_W      = 36;
    localparam int LANES      = 4;
    localparam int LANE_W     = 9;
    localparam int NIBBLE_W   = 4;
    localparam int LINE_W     = 2 * MAX_W;
    localparam logic [MAX_W-1:0] DATA_RESET = 36'h000000000;

    typedef enum logic [1:0] {
        CFG_X8  = 2'b00,
        CFG_X9  = 2'b01,
        CFG_X18 = 2'b10,
        CFG_X36 = 2'b11
    } width_cfg_type;

    typedef struct packed {
        logic [MAX_W-1:0] data;
        logic [LANES-1:0] sel_n;
    } beat_type;

    function automatic int cfg_width(input width_cfg_type cfg);
        case (cfg)
            CFG_X8:  cfg_width = 8;
            CFG_X9:  cfg_width = 9;
            CFG_X18: cfg_width = 18;
            default: cfg_width = 36;
        endcase
    endfunction : cfg_width

    // bit enables from active-low lane selects; bits above the width stay off
    function automatic logic [MAX_W-1:0] lane_mask(input width_cfg_type cfg, input logic [LANES-1:0] sel_n);
        int lane_size;
        lane_mask = '0;
        lane_size = (cfg == CFG_X8) ? NIBBLE_W : LANE_W;
        for (int i = 0; i < MAX_W; i++) begin
            if (i < cfg_width(cfg)) begin
                lane_mask[i] = ~sel_n[i / lane_size];
            end
        end
    endfunction : lane_mask

endpackage : sram_wmask_pkg

// >>> hw/sram_line_mem.sv
// two-word line memory with bit-enabled write and registered read
`timescale 1ns/1ps
`default_nettype none
module sram_line_mem #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 72
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    input  wire logic              i_we,
    input  wire logic [ADDR_W-1:0] i_waddr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [DATA_W-1:0] i_ben,
    input  wire logic [ADDR_W-1:0] i_raddr,
    output logic      [DATA_W-1:0] o_rdata
);

    logic [DATA_W-1:0] mem [2**ADDR_W];

    // unselected bits keep their stored value
    always_ff @(posedge i_clk_sys) begin
        if (i_we) begin
            mem[i_waddr] <= (mem[i_waddr] & ~i_ben) | (i_wdata & i_ben);
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule : sram_line_mem
`default_nettype wire

// >>> tb/sram_host_model.sv
// host controller model driving the sram write and read ports
`timescale 1ns/1ps
`default_nettype none
module sram_host_model (
    input  wire logic        i_clk_sys,
    output var  logic        o_k,
    output var  logic        o_k_n,
    output var  logic        o_c,
    output var  logic        o_c_n,
    output var  logic        o_wps_n,
    output var  logic        o_rps_n,
    output var  logic [3:0]  o_addr,
    output var  logic [35:0] o_data,
    output var  logic [5:0]  o_sel_n
);
    initial begin
        {o_k, o_k_n, o_c, o_c_n} = 4'h0;
        {o_wps_n, o_rps_n} = 2'h3;
        o_addr = 4'h0;
        o_data = 36'h000000000;
        o_sel_n = 6'h3F;
    end

    // ============================================================
    // clock levels {k, k_n, c, c_n}, parked between frames
    task automatic drive_clocks(input logic [3:0] v);
        @(posedge i_clk_sys);
        {o_k, o_k_n, o_c, o_c_n} <= v;
    endtask : drive_clocks

    // ============================================================
    // write burst, beat selects chosen per beat
    task automatic write_burst(input logic [3:0] a, input logic [35:0] d0, input logic [5:0] s0,
                               input logic [35:0] d1, input logic [5:0] s1);
        @(posedge i_clk_sys);
        {o_k, o_wps_n} <= 2'b10;
        o_addr <= a;
        o_data <= d0;
        o_sel_n <= s0;
        @(posedge i_clk_sys);
        {o_k, o_k_n, o_wps_n} <= 3'b011;
        o_data <= d1;
        o_sel_n <= s1;
        @(posedge i_clk_sys);
        o_k_n <= 1'b0;
        o_addr <= ~a;
        o_data <= ~d1;
        o_sel_n <= ~s1;
    endtask : write_burst

    // read request, then the next k rise
    task automatic read_req(input logic [3:0] a);
        @(posedge i_clk_sys);
        {o_k, o_rps_n} <= 2'b10;
        o_addr <= a;
        @(posedge i_clk_sys);
        {o_k, o_rps_n} <= 2'b01;
        o_addr <= ~a;
        drive_clocks(4'h8);
        drive_clocks(4'h0);
    endtask : read_req
endmodule : sram_host_model
`default_nettype wire

// >>> tb/sram_byte_write_mask_bench.sv
// self-checking bench: four widths share one host, checked by readback
`timescale 1ns/1ps
`default_nettype none
module sram_byte_write_mask_bench;
    logic        i_clk_sys = 1'b0;
    logic        i_rst = 1'b1;
    wire         k, k_n, c, c_n, wps_n, rps_n;
    wire  [3:0]  addr;
    wire  [35:0] data;
    wire  [5:0]  sel_n;
    wire  [35:0] rdata [4];
    wire  [3:0]  oe;
    wire  [3:0]  sc;
    logic [71:0] exp_mem [4][16];
    int          failures = 0;
    int          checks_done = 0;
    logic [5:0]  pats [6] = '{6'h2E, 6'h1D, 6'h3B, 6'h17, 6'h3F, 6'h00};

    always #2.5 i_clk_sys = ~i_clk_sys;

    sram_host_model u_host (
        .i_clk_sys (i_clk_sys),
        .o_k       (k),
        .o_k_n     (k_n),
        .o_c       (c),
        .o_c_n     (c_n),
        .o_wps_n   (wps_n),
        .o_rps_n   (rps_n),
        .o_addr    (addr),
        .o_data    (data),
        .o_sel_n   (sel_n)
    );

    // one instance per width, index equals the width code
    for (genvar g = 0; g < 4; g++) begin : gen_cfg
        sram_wmask_top #(
            .CFG    (sram_wmask_pkg::width_cfg_type'(g)),
            .ADDR_W (4)
        ) u_dut (
            .i_clk_sys                  (i_clk_sys),
            .i_rst                      (i_rst),
            .i_k                        (k),
            .i_k_n                      (k_n),
            .i_c                        (c),
            .i_c_n                      (c_n),
            .i_write_port_select_n      (wps_n),
            .i_read_port_select_n       (rps_n),
            .i_addr                     (addr),
            .i_data                     (data),
            .i_lane0_write_select_n     (sel_n[0]),
            .i_lane1_write_select_n     (sel_n[1]),
            .i_lane2_write_select_n     (sel_n[2]),
            .i_lane3_write_select_n     (sel_n[3]),
            .i_low_half_write_select_n  (sel_n[4]),
            .i_high_half_write_select_n (sel_n[5]),
            .o_rdata                    (rdata[g]),
            .o_rdata_oe                 (oe[g]),
            .o_single_clock             (sc[g])
        );
    end

    // ============================================================
    // expectation helpers
    function automatic int wid(input int g);
        return (g == 0) ? 8 : (g == 1) ? 9 : 18 * (g - 1);
    endfunction : wid

    function automatic logic [35:0] wm(input int g);
        return 36'hFFFFFFFFF >> (36 - wid(g));
    endfunction : wm

    function automatic logic [35:0] en_bits(input int g, input logic [5:0] s);
        en_bits = '0;
        for (int i = 0; i < wid(g); i++) begin
            en_bits[i] = (g == 0) ? ~s[4 + i / 4] : ~s[i / 9];
        end
    endfunction : en_bits

    task automatic close_out;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wait_oe(input logic v);
        int n;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end while (oe !== {4{v}} && n < 10);
        check("read enable", {32'h0, oe}, {32'h0, {4{v}}});
        if (oe !== {4{v}}) begin
            close_out();
        end
    endtask : wait_oe

    // ============================================================
    // scenarios
    task automatic do_reset(input logic [3:0] lvl);
        u_host.drive_clocks(lvl);
        i_rst <= 1'b1;
        repeat (12) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(posedge i_clk_sys);
        #1;
        check("strap", {32'h0, sc}, {32'h0, {4{lvl == 4'h3}}});
        check("idle enable", {32'h0, oe}, 36'h0);
        for (int g = 0; g < 4; g++) begin
            check("idle data", rdata[g], 36'h0);
        end
        u_host.drive_clocks(4'h0);
        @(posedge i_clk_sys);
    endtask : do_reset

    task automatic wr(input logic [3:0] a, input logic [35:0] d0, input logic [5:0] s0,
                      input logic [35:0] d1, input logic [5:0] s1);
        logic [71:0] en;
        u_host.write_burst(a, d0, s0, d1, s1);
        for (int g = 0; g < 4; g++) begin
            en = {en_bits(g, s1), en_bits(g, s0)};
            exp_mem[g][a] = (exp_mem[g][a] & ~en) | ({d1, d0} & en);
        end
    endtask : wr

    // launch edges come from the output clocks, or from the input clocks in single clock mode
    task automatic rd(input logic [3:0] a, input logic single);
        logic [3:0] lo;
        logic [3:0] hi;
        lo = single ? 4'h4 : 4'h1;
        hi = single ? 4'h8 : 4'h2;
        u_host.read_req(a);
        u_host.drive_clocks(lo);
        wait_oe(1'b1);
        for (int g = 0; g < 4; g++) begin
            check("first beat", rdata[g] & wm(g), exp_mem[g][a][35:0] & wm(g));
        end
        u_host.drive_clocks(hi);
        repeat (3) @(posedge i_clk_sys);
        #1;
        for (int g = 0; g < 4; g++) begin
            check("second beat", rdata[g] & wm(g), exp_mem[g][a][71:36] & wm(g));
        end
        u_host.drive_clocks(lo);
        wait_oe(1'b0);
        u_host.drive_clocks(4'h0);
    endtask : rd

    initial begin
        do_reset(4'h0);
        for (int a = 0; a < 4; a++) begin
            wr(4'(a), {9{4'(a)}}, 6'h00, ~{9{4'(a)}}, 6'h00);
        end
        for (int i = 0; i < 6; i++) begin
            wr(4'h1, {9{4'(i + 8)}}, pats[i], {9{4'(i + 2)}}, pats[(i + 1) % 6]);
            rd(4'h1, 1'b0);
        end
        wr(4'h2, 36'h5A5A5A5A5, 6'h3F, 36'hC3C3C3C3C, 6'h00);
        wr(4'h3, 36'h696969696, 6'h00, 36'h0F0F0F0F0, 6'h3F);
        rd(4'h2, 1'b0);
        rd(4'h3, 1'b0);
        do_reset(4'h3);
        // clocks parked high, then restarted in single clock mode
        u_host.drive_clocks(4'hF);
        repeat (4) @(posedge i_clk_sys);
        u_host.drive_clocks(4'h0);
        wr(4'h1, 36'h123456789, 6'h2A, 36'h9ABCDEF01, 6'h15);
        rd(4'h1, 1'b1);
        close_out();
    end
endmodule : sram_byte_write_mask_bench
`default_nettype wire
